// [design/smx_reg_bank.sv]
// Slot multiplexer configuration bank behind a two-wire serial target
// How it works
// (RL1) Address 00h reads a fixed eight-bit maker and revision code.
// (RL2) Maker code sits in the upper nibble, revision in the lower.
// (RL3) Maker nibble is a constant; only the revision nibble may differ.
// (RL4) Address 01h reads a fixed eight-bit driver version, never writable.
// (RL5) Driver version is valid straight after reset, no setup needed.
// (RL6) Writes to read-only or reserved places are dropped; reads give reset contents, except live status at 04h.
// (RL7) All access is by a fast-mode two-wire target; the processor is master.
// (RL8) Reading status clears every interrupt flag that read as one.
// (RL9) Two registers load eight-bit down-counting debouncers for battery and shutdown.
`timescale 1ns/1ps
module smx_reg_bank
	import smx_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = 7'h2A, // Arbitrary bus address
	parameter logic [3:0] MFR_ID      = 4'hA,  // Arbitrary maker code
	parameter logic [3:0] HW_REV      = 4'h3,  // Arbitrary revision code
	parameter logic [7:0] DRV_VERSION = 8'h05, // Arbitrary driver version
	parameter int         DEB_W       = 8
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Two-wire serial bus
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Detection inputs
	input  wire logic       battery_sense_input,
	input  wire logic       shutdown_input,
	// Control towards the rest of the chip
	output logic [7:0]      slot_ctrl,
	output logic [7:0]      clk_ctrl,
	output logic [7:0]      dev_ctrl,
	output logic [7:0]      gp_ctrl,
	output logic [7:0]      status
);
	localparam int TW = $clog2(TICK_CYC);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

	// Pin synchronisers, bits are {shutdown, battery, sda, scl}
	logic [3:0]    s1_reg;
	logic [3:0]    s2_reg;
	logic [3:0]    s3_reg;
	logic [3:0]    filt_reg;
	logic [3:0]    filt_next;
	logic [3:0]    prev_reg;
	// Tick divider
	logic [TW-1:0] tdiv_reg;
	logic [TW-1:0] tdiv_next;
	logic          tick_reg;
	logic          tick_next;
	// Serial target
	smx_state_t    st_reg;
	smx_state_t    st_next;
	logic [7:0]    sh_reg;
	logic [7:0]    sh_next;
	logic [3:0]    cnt_reg;
	logic [3:0]    cnt_next;
	logic [7:0]    ptr_reg;
	logic [7:0]    ptr_next;
	logic          hp_reg;
	logic          hp_next;
	logic          rw_reg;
	logic          rw_next;
	logic          mack_reg;
	logic          mack_next;
	logic          oe_n_reg;
	logic          oe_n_next;
	logic          wr_stb;
	logic          ld_tx;
	logic          rd_stat;
	logic [7:0]    rd_byte;
	// Registers
	logic [7:0]    slot_reg;
	logic [7:0]    slot_next;
	logic [7:0]    bdeb_reg;
	logic [7:0]    bdeb_next;
	logic [7:0]    sdeb_reg;
	logic [7:0]    sdeb_next;
	logic [7:0]    clkc_reg;
	logic [7:0]    clkc_next;
	logic [7:0]    dev_reg;
	logic [7:0]    dev_next;
	logic [7:0]    gp_reg;
	logic [7:0]    gp_next;
	logic [7:0]    test_reg [5];
	logic [7:0]    test_next [5];
	logic          sint_reg;
	logic          sint_next;
	logic          bint_reg;
	logic          bint_next;
	logic [7:0]    stat_w;
	logic          shd_set;
	logic          bat_set;
	logic          in_test;
	logic [2:0]    tidx;
	// Bus events
	logic          scl_rise;
	logic          scl_fall;
	logic          start_ev;
	logic          stop_ev;
	logic          sda_f;

	smx_deb_if #(.W(DEB_W)) bat_if ();
	smx_deb_if #(.W(DEB_W)) shd_if ();

	// Slot status: isolated or active only counts while the regulator is on
	function automatic logic [1:0] slot_st(input logic on, input logic [1:0] s);
		if (!on)
			return SS_OFF;
		return (s == SS_OFF) ? SS_POWERED : s;
	endfunction : slot_st

	// A change counts only once the second and third stages agree
	always_comb begin
		filt_next = filt_reg;
		for (int i = 0; i < 4; i++) begin
			if (s2_reg[i] == s3_reg[i])
				filt_next[i] = s3_reg[i];
		end
		tick_next = (tdiv_reg == TICK_LAST);
		tdiv_next = tick_next ? '0 : tdiv_reg + 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg   <= 4'h3;
			s2_reg   <= 4'h3;
			s3_reg   <= 4'h3;
			filt_reg <= 4'h3;
			prev_reg <= 4'h3;
			tdiv_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			s1_reg   <= {shutdown_input, battery_sense_input, sda_in, scl};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
			prev_reg <= filt_reg;
			tdiv_reg <= tdiv_next;
			tick_reg <= tick_next;
		end
	end

	// Bus conditions seen on the filtered lines
	assign sda_f    = filt_reg[1];
	assign scl_rise = filt_reg[0] & ~prev_reg[0];
	assign scl_fall = ~filt_reg[0] & prev_reg[0];
	assign start_ev = filt_reg[0] & prev_reg[0] & prev_reg[1] & ~sda_f; // RL7
	assign stop_ev  = filt_reg[0] & prev_reg[0] & ~prev_reg[1] & sda_f; // RL7

	// Read multiplexer; reserved and unmapped places read as zero
	always_comb begin
		tidx    = 3'(ptr_reg - A_TEST_LO);
		in_test = (ptr_reg >= A_TEST_LO) && (ptr_reg <= A_TEST_HI);
		case (ptr_reg)
			A_HW_ID:     rd_byte = {MFR_ID, HW_REV}; // RL1 RL2 RL3
			A_DRV_VER:   rd_byte = DRV_VERSION; // RL4 RL5
			A_STATUS:    rd_byte = stat_w;
			A_SLOT_CTRL: rd_byte = slot_reg;
			A_BAT_DEB:   rd_byte = bdeb_reg;
			A_SHD_DEB:   rd_byte = sdeb_reg;
			A_CLK_CTRL:  rd_byte = clkc_reg;
			A_DEV_CTRL:  rd_byte = dev_reg;
			A_GP:        rd_byte = gp_reg;
			default:     rd_byte = in_test ? test_reg[tidx] : RST_ZERO; // RL6
		endcase
	end

	// Target sequencer: address, pointer byte, then data with auto increment
	always_comb begin
		st_next   = st_reg;
		sh_next   = sh_reg;
		cnt_next  = cnt_reg;
		ptr_next  = ptr_reg;
		hp_next   = hp_reg;
		rw_next   = rw_reg;
		mack_next = mack_reg;
		oe_n_next = oe_n_reg;
		wr_stb    = 1'b0;
		ld_tx     = 1'b0;
		if (stop_ev) begin
			st_next   = ST_IDLE;
			oe_n_next = 1'b1;
		end else if (start_ev) begin
			st_next   = ST_ADDR; // RL7
			cnt_next  = 4'h0;
			hp_next   = 1'b0;
			oe_n_next = 1'b1;
		end else if (scl_rise) begin
			case (st_reg)
				ST_ADDR, ST_WR: begin
					sh_next  = {sh_reg[6:0], sda_f};
					cnt_next = cnt_reg + 4'h1;
				end
				ST_RD:    cnt_next = cnt_reg + 4'h1;
				ST_ACK_R: mack_next = ~sda_f;
				default:  ;
			endcase
		end else if (scl_fall) begin
			case (st_reg)
				ST_ADDR: begin
					if (cnt_reg == 4'h8) begin
						if (sh_reg[7:1] == TARGET_ADDR) begin
							st_next   = ST_ACK_A;
							rw_next   = sh_reg[0];
							oe_n_next = 1'b0;
						end else begin
							st_next = ST_IDLE;
						end
					end
				end
				ST_WR: begin
					if (cnt_reg == 4'h8) begin
						st_next   = ST_ACK_W;
						oe_n_next = 1'b0;
						if (hp_reg) begin
							wr_stb   = 1'b1;
							ptr_next = ptr_reg + 8'h01;
						end else begin
							ptr_next = sh_reg;
							hp_next  = 1'b1;
						end
					end
				end
				ST_ACK_A, ST_ACK_W: begin
					if (rw_reg) begin
						ld_tx = 1'b1;
					end else begin
						st_next   = ST_WR;
						cnt_next  = 4'h0;
						oe_n_next = 1'b1;
					end
				end
				ST_RD: begin
					if (cnt_reg == 4'h8) begin
						st_next   = ST_ACK_R;
						oe_n_next = 1'b1;
					end else begin
						sh_next   = {sh_reg[6:0], 1'b0};
						oe_n_next = sh_reg[6];
					end
				end
				ST_ACK_R: begin
					if (mack_reg)
						ld_tx = 1'b1;
					else
						st_next = ST_IDLE;
				end
				default: st_next = ST_IDLE;
			endcase
		end
		// Byte to send is latched here, so a status read sees one snapshot
		if (ld_tx) begin
			st_next   = ST_RD;
			sh_next   = rd_byte;
			ptr_next  = ptr_reg + 8'h01;
			cnt_next  = 4'h0;
			oe_n_next = rd_byte[7];
		end
	end

	assign rd_stat = ld_tx && (ptr_reg == A_STATUS);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg   <= ST_IDLE;
			sh_reg   <= 8'h00;
			cnt_reg  <= 4'h0;
			ptr_reg  <= 8'h00;
			hp_reg   <= 1'b0;
			rw_reg   <= 1'b0;
			mack_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			st_reg   <= st_next;
			sh_reg   <= sh_next;
			cnt_reg  <= cnt_next;
			ptr_reg  <= ptr_next;
			hp_reg   <= hp_next;
			rw_reg   <= rw_next;
			mack_reg <= mack_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// Debouncer hookup
	assign bat_if.tick     = tick_reg;
	assign bat_if.level_in = filt_reg[2];
	assign bat_if.count    = DEB_W'(bdeb_reg); // RL9
	assign shd_if.tick     = tick_reg;
	assign shd_if.level_in = filt_reg[3];
	assign shd_if.count    = DEB_W'(sdeb_reg); // RL9

	smx_debounce #(.W(DEB_W)) u_bat_deb (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (bat_if)
	);
	smx_debounce #(.W(DEB_W)) u_shd_deb (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (shd_if)
	);

	// Flags raise only when the accepted level turns active and is enabled
	assign shd_set = shd_if.changed & (shd_if.state ^ dev_reg[DC_SHD_LVL]) & dev_reg[DC_SHD_IE];
	assign bat_set = bat_if.changed & (bat_if.state ^ dev_reg[DC_BAT_LVL]) & dev_reg[DC_BAT_IE];
	assign stat_w  = {slot_st(slot_reg[SC_S2_ON], slot_reg[SC_S2_ST+:2]),
		slot_st(slot_reg[SC_S1_ON], slot_reg[SC_S1_ST+:2]),
		bint_reg, bat_if.state ^ dev_reg[DC_BAT_LVL], sint_reg, filt_reg[3]};

	// Register writes; read-only and reserved addresses fall to default
	always_comb begin
		slot_next = slot_reg;
		bdeb_next = bdeb_reg;
		sdeb_next = sdeb_reg;
		clkc_next = clkc_reg;
		dev_next  = dev_reg;
		gp_next   = gp_reg;
		test_next = test_reg;
		if (wr_stb) begin
			case (ptr_reg)
				A_SLOT_CTRL: slot_next = sh_reg;
				A_BAT_DEB:   bdeb_next = sh_reg; // RL9
				A_SHD_DEB:   sdeb_next = sh_reg; // RL9
				A_CLK_CTRL:  clkc_next = sh_reg;
				A_DEV_CTRL:  dev_next  = sh_reg;
				A_GP:        gp_next   = sh_reg;
				default: begin
					if (in_test)
						test_next[tidx] = sh_reg;
				end // RL6
			endcase
		end
		// A new event in the clearing cycle wins over the clear
		sint_next = shd_set | (sint_reg & ~rd_stat); // RL8
		bint_next = bat_set | (bint_reg & ~rd_stat); // RL8
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_reg <= RST_ZERO;
			bdeb_reg <= RST_DEB;
			sdeb_reg <= RST_DEB;
			clkc_reg <= RST_ZERO;
			dev_reg  <= RST_ZERO;
			gp_reg   <= RST_ZERO;
			for (int i = 0; i < 5; i++)
				test_reg[i] <= RST_ZERO;
			sint_reg <= 1'b0;
			bint_reg <= 1'b0;
		end else begin
			slot_reg <= slot_next;
			bdeb_reg <= bdeb_next;
			sdeb_reg <= sdeb_next;
			clkc_reg <= clkc_next;
			dev_reg  <= dev_next;
			gp_reg   <= gp_next;
			test_reg <= test_next;
			sint_reg <= sint_next;
			bint_reg <= bint_next;
		end
	end

	// Outputs; sda is open drain so only the enable moves
	assign sda_out   = 1'b0;
	assign sda_oe_n  = oe_n_reg;
	assign slot_ctrl = slot_reg;
	assign clk_ctrl  = clkc_reg;
	assign dev_ctrl  = dev_reg;
	assign gp_ctrl   = gp_reg;
	assign status    = stat_w;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_hwid_value: assert property ( // RL1
		(ld_tx && ptr_reg == A_HW_ID) |=> sh_reg == {MFR_ID, HW_REV})
		else $error("identity byte not loaded for sending");
	a_mfr_nibble: assert property ( // RL2
		(ld_tx && ptr_reg == A_HW_ID) |=> (sh_reg[7:4] == MFR_ID) && (oe_n_reg == MFR_ID[3]))
		else $error("maker code not in the upper nibble");
	a_mfr_stable: assert property ( // RL3
		(ptr_reg == A_HW_ID) |-> rd_byte[7:4] == MFR_ID)
		else $error("maker nibble changed");
	a_drv_version: assert property ( // RL4
		(ld_tx && ptr_reg == A_DRV_VER) |=> sh_reg == DRV_VERSION)
		else $error("driver version byte wrong");
	a_drv_after_rst: assert property ( // RL5
		(ptr_reg == A_DRV_VER) |-> rd_byte == DRV_VERSION)
		else $error("driver version not readable");
	a_rsvd_reads_zero: assert property ( // RL6
		(ptr_reg == A_RSVD) |-> rd_byte == RST_ZERO)
		else $error("reserved place reads nonzero");
	a_idle_release: assert property ( // RL7
		(st_reg == ST_IDLE || st_reg == ST_ADDR) |-> sda_oe_n)
		else $error("data line driven outside a selected transfer");
	a_clear_on_read: assert property ( // RL8
		(rd_stat && !shd_set && !bat_set) |=> !sint_reg && !bint_reg)
		else $error("status read did not clear flags");
	a_set_wins: assert property ( // RL8
		(shd_set || bat_set) |=> (sint_reg || !$past(shd_set)) && (bint_reg || !$past(bat_set)))
		else $error("event lost against a clear");
endmodule : smx_reg_bank

// [inc/smx_pkg.sv]
// Constants and types for the slot multiplexer register bank
package smx_pkg;
	// Core clock and the slow timing base for debouncing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 31250;
	localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// Register byte addresses
	localparam logic [7:0] A_HW_ID     = 8'h00;
	localparam logic [7:0] A_DRV_VER   = 8'h01;
	localparam logic [7:0] A_STATUS    = 8'h04;
	localparam logic [7:0] A_SLOT_CTRL = 8'h08;
	localparam logic [7:0] A_BAT_DEB   = 8'h0A;
	localparam logic [7:0] A_SHD_DEB   = 8'h0B;
	localparam logic [7:0] A_RSVD      = 8'h0C;
	localparam logic [7:0] A_CLK_CTRL  = 8'h0D;
	localparam logic [7:0] A_DEV_CTRL  = 8'h0E;
	localparam logic [7:0] A_TEST_LO   = 8'h10;
	localparam logic [7:0] A_TEST_HI   = 8'h14;
	localparam logic [7:0] A_GP        = 8'h15;
	// Reset values
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] RST_DEB     = 8'h04;
	// Status field positions
	localparam int ST_SHD_LVL = 0;
	localparam int ST_SHD_INT = 1;
	localparam int ST_BAT     = 2;
	localparam int ST_BAT_INT = 3;
	// Slot control field positions
	localparam int SC_S1_ON = 0;
	localparam int SC_S1_ST = 2;
	localparam int SC_S2_ON = 4;
	localparam int SC_S2_ST = 6;
	// Device control field positions
	localparam int DC_BAT_IE  = 2;
	localparam int DC_BAT_LVL = 3;
	localparam int DC_SHD_IE  = 5;
	localparam int DC_SHD_LVL = 6;
	// Slot status codes
	localparam logic [1:0] SS_OFF     = 2'h0;
	localparam logic [1:0] SS_POWERED = 2'h2;
	// Serial target states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_ACK_A = 3'h3,
		ST_WR    = 3'h2,
		ST_ACK_W = 3'h6,
		ST_RD    = 3'h7,
		ST_ACK_R = 3'h5
	} smx_state_t;
endpackage : smx_pkg

// [inc/smx_deb_if.sv]
// Carrier between the register bank and one debounce counter
`timescale 1ns/1ps
interface smx_deb_if #(parameter int W = 8) ();
	logic         tick;
	logic         level_in;
	logic [W-1:0] count;
	logic         state;
	logic         changed;
	modport core (input tick, input level_in, input count, output state, output changed);
	modport bank (output tick, output level_in, output count, input state, input changed);
endinterface : smx_deb_if

// [design/smx_debounce.sv]
// Down-counting debounce filter for one input level
`timescale 1ns/1ps
module smx_debounce
	import smx_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bank side
	smx_deb_if.core  d
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         st_reg;
	logic         st_next;
	logic         chg_reg;
	logic         chg_next;

	// Count down only while the input differs from the accepted level
	always_comb begin
		cnt_next = cnt_reg;
		st_next  = st_reg;
		chg_next = 1'b0;
		if (d.level_in == st_reg) begin
			cnt_next = d.count; // RL9
		end else if (d.tick) begin
			if (cnt_reg == '0) begin
				st_next  = d.level_in; // RL9
				chg_next = 1'b1;
				cnt_next = d.count;
			end else begin
				cnt_next = cnt_reg - 1'b1; // RL9
			end
		end
	end

	// State registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			st_reg  <= 1'b0;
			chg_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			st_reg  <= st_next;
			chg_reg <= chg_next;
		end
	end

	assign d.state   = st_reg;
	assign d.changed = chg_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_deb_count_down: assert property ( // RL9
		(d.tick && d.level_in != st_reg && cnt_reg != '0) |=> cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("debounce count did not step down");
	a_deb_accept: assert property ( // RL9
		(d.tick && d.level_in != st_reg && cnt_reg == '0) |=> (st_reg == $past(d.level_in)) && chg_reg)
		else $error("expired debounce did not accept the new level");
endmodule : smx_debounce

// [tb/smx_bb_master.sv]
// Two-wire bus master model standing in for the baseband processor
`timescale 1ns/1ps
module smx_bb_master
	import smx_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h35, // Arbitrary bus address
	parameter int         HALF     = 15
) (
	// Clock
	input  wire logic clk,
	// Bus wires
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_drv_n
);
	logic [7:0] wr_buf [0:31];
	logic [7:0] rd_buf [0:31];
	logic       nack_seen;

	// Bus idles high until the first frame
	initial begin
		scl       = 1'b1;
		sda_drv_n = 1'b1;
		nack_seen = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask : gap

	// Data moves a few cycles after SCL fell, so the filtered copies never race
	task automatic bit_slot(input logic b, output logic seen);
		sda_drv_n = b;
		gap(HALF);
		scl = 1'b1;
		gap(HALF);
		seen = sda_wire;
		scl = 1'b0;
		gap(3);
	endtask : bit_slot

	// START or repeated START, leaves SCL low
	task automatic start_cond();
		sda_drv_n = 1'b1;
		gap(HALF);
		scl = 1'b1;
		gap(HALF);
		sda_drv_n = 1'b0;
		gap(HALF);
		scl = 1'b0;
		gap(3);
	endtask : start_cond

	task automatic stop_cond();
		sda_drv_n = 1'b0;
		gap(HALF);
		scl = 1'b1;
		gap(HALF);
		sda_drv_n = 1'b1;
		gap(HALF);
	endtask : stop_cond

	// Byte out MSB first, returns the target acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
		bit_slot(1'b1, s);
		ack = (s === 1'b0);
	endtask : send_byte

	// Block transfers flag any missing acknowledge
	task automatic send_chk(input logic [7:0] b);
		logic a;
		send_byte(b, a);
		if (!a) nack_seen = 1'b1;
	endtask : send_chk

	task automatic write_block(input logic [7:0] ptr, input int n);
		start_cond();
		send_chk({BUS_ADDR, 1'b0});
		send_chk(ptr);
		for (int i = 0; i < n; i++) send_chk(wr_buf[i]);
		stop_cond();
	endtask : write_block

	// Pointer set by a write, then repeated START and read; NACK on the last byte
	task automatic read_block(input logic [7:0] ptr, input int n);
		logic s;
		start_cond();
		send_chk({BUS_ADDR, 1'b0});
		send_chk(ptr);
		start_cond();
		send_chk({BUS_ADDR, 1'b1});
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_slot(1'b1, s);
				rd_buf[k][i] = s;
			end
			bit_slot(k == n - 1, s);
		end
		stop_cond();
	endtask : read_block

	task automatic probe(input logic [6:0] addr, output logic ack);
		start_cond();
		send_byte({addr, 1'b0}, ack);
		stop_cond();
	endtask : probe
endmodule : smx_bb_master

// [tb/smx_reg_bank_tb.sv]
// Self-checking bench for the slot multiplexer register bank
`timescale 1ns/1ps
module smx_reg_bank_tb
	import smx_pkg::*;
();
	localparam logic [6:0] BUS_A = 7'h35; // Arbitrary bus address
	localparam logic [3:0] MFR   = 4'h6;  // Arbitrary maker code
	localparam logic [3:0] REV   = 4'h9;  // Arbitrary revision code
	localparam logic [7:0] DRV   = 8'h3C; // Arbitrary driver version
	localparam int         NREG  = 24;

	logic        clk;
	logic        sys_rst;
	logic        scl;
	logic        sda_wire;
	logic        sda_drv_n;
	logic        sda_out;
	logic        sda_oe_n;
	logic        battery_sense_input;
	logic        shutdown_input;
	logic [7:0]  slot_ctrl;
	logic [7:0]  clk_ctrl;
	logic [7:0]  dev_ctrl;
	logic [7:0]  gp_ctrl;
	logic [7:0]  status;
	logic [31:0] lfsr_q;
	logic [7:0]  s8;
	logic        ack;
	int          miscompares;
	int          cmp_count;
	int          w;
	int          cnt;
	int          fbit;
	int          lbit;
	logic        in_win;

	// Open-drain wire with pull-up
	assign sda_wire = (sda_oe_n ? 1'b1 : sda_out) & sda_drv_n;

	smx_reg_bank #(.TARGET_ADDR(BUS_A), .MFR_ID(MFR), .HW_REV(REV), .DRV_VERSION(DRV))
		i_smx_reg_bank (
		.clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .battery_sense_input(battery_sense_input),
		.shutdown_input(shutdown_input), .slot_ctrl(slot_ctrl), .clk_ctrl(clk_ctrl),
		.dev_ctrl(dev_ctrl), .gp_ctrl(gp_ctrl), .status(status));

	smx_bb_master #(.BUS_ADDR(BUS_A)) i_smx_bb_master (
		.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv_n(sda_drv_n));

	always #50 clk = ~clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction : lfsr_next

	function automatic logic [7:0] exp_reset(input logic [7:0] a);
		case (a)
			A_HW_ID:              return {MFR, REV};
			A_DRV_VER:            return DRV;
			A_BAT_DEB, A_SHD_DEB: return RST_DEB;
			default:              return RST_ZERO;
		endcase
	endfunction : exp_reset

	function automatic logic is_rw(input logic [7:0] a);
		return (a inside {A_SLOT_CTRL, A_BAT_DEB, A_SHD_DEB, A_CLK_CTRL, A_DEV_CTRL, A_GP})
			|| (a >= A_TEST_LO && a <= A_TEST_HI);
	endfunction : is_rw

	function automatic logic [1:0] slot_stat(input logic on, input logic [1:0] st);
		return !on ? SS_OFF : ((st == SS_OFF) ? SS_POWERED : st);
	endfunction : slot_stat

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge clk);
	endtask : do_reset

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		battery_sense_input = 1'b0;
		shutdown_input = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		lfsr_q = 32'hE564;
		@(negedge clk);
		do_reset();
		// Power-up contents of the whole map, pointer auto-increments
		i_smx_bb_master.read_block(8'h00, NREG);
		for (int i = 0; i < NREG; i++)
			check("reset byte", i_smx_bb_master.rd_buf[i], exp_reset(i));
		check("maker nibble", {4'h0, i_smx_bb_master.rd_buf[0][7:4]}, {4'h0, MFR});
		check("revision nibble", {4'h0, i_smx_bb_master.rd_buf[0][3:0]}, {4'h0, REV});
		// Random bytes across the map except device control, which gets zero; read-only and unmapped places included
		for (int i = 0; i < NREG; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			i_smx_bb_master.wr_buf[i] = (i == A_DEV_CTRL) ? RST_ZERO : lfsr_q[7:0];
		end
		i_smx_bb_master.write_block(8'h00, NREG);
		i_smx_bb_master.read_block(8'h00, NREG);
		s8 = i_smx_bb_master.wr_buf[A_SLOT_CTRL];
		s8 = {slot_stat(s8[SC_S2_ON], s8[SC_S2_ST+:2]), slot_stat(s8[SC_S1_ON], s8[SC_S1_ST+:2]),
			4'h0};
		for (int i = 0; i < NREG; i++)
			check("readback", i_smx_bb_master.rd_buf[i], is_rw(i) ? i_smx_bb_master.wr_buf[i] :
				(i == A_STATUS) ? s8 : exp_reset(i));
		check("slot_ctrl", slot_ctrl, i_smx_bb_master.wr_buf[A_SLOT_CTRL]);
		check("clk_ctrl", clk_ctrl, i_smx_bb_master.wr_buf[A_CLK_CTRL]);
		check("gp_ctrl", gp_ctrl, i_smx_bb_master.wr_buf[A_GP]);
		check("status", status, s8);
		check("block acks", {7'h0, i_smx_bb_master.nack_seen}, 8'h00);
		// Only the own address is acknowledged
		i_smx_bb_master.probe(BUS_A ^ 7'h01, ack);
		check("foreign ack", {7'h0, ack}, 8'h00);
		i_smx_bb_master.probe(BUS_A, ack);
		check("own ack", {7'h0, ack}, 8'h01);
		// Debounce and interrupt flag: battery first, then shutdown
		for (int k = 0; k < 2; k++) begin
			fbit = k ? ST_SHD_INT : ST_BAT_INT;
			lbit = k ? ST_SHD_LVL : ST_BAT;
			lfsr_q = lfsr_next(lfsr_q);
			cnt = lfsr_q[1:0];
			i_smx_bb_master.wr_buf[0] = 8'(cnt);
			i_smx_bb_master.write_block(k ? A_SHD_DEB : A_BAT_DEB, 1);
			i_smx_bb_master.wr_buf[0] = 8'h01 << (k ? DC_SHD_IE : DC_BAT_IE);
			i_smx_bb_master.write_block(A_DEV_CTRL, 1);
			check("dev_ctrl", dev_ctrl, i_smx_bb_master.wr_buf[0]);
			if (k) shutdown_input = 1'b1;
			else battery_sense_input = 1'b1;
			for (w = 0; w < (cnt + 2) * TICK_CYC && status[fbit] !== 1'b1; w++)
				@(negedge clk);
			in_win = (w >= cnt * TICK_CYC) && (w <= (cnt + 1) * TICK_CYC + 20);
			check("debounce delay", {7'h0, in_win}, 8'h01);
			check("level bit", {7'h0, status[lbit]}, 8'h01);
			i_smx_bb_master.read_block(A_STATUS, 1);
			check("flag read", {7'h0, i_smx_bb_master.rd_buf[0][fbit]}, 8'h01);
			check("flag after", {7'h0, status[fbit]}, 8'h00);
			i_smx_bb_master.read_block(A_STATUS, 1);
			check("flag reread", {7'h0, i_smx_bb_master.rd_buf[0][fbit]}, 8'h00);
		end
		// Inverted level select: now a falling battery pin is the active change
		i_smx_bb_master.wr_buf[0] = (8'h01 << DC_BAT_LVL) | (8'h01 << DC_BAT_IE);
		i_smx_bb_master.write_block(A_DEV_CTRL, 1);
		check("inverted idle level", {7'h0, status[ST_BAT]}, 8'h00);
		battery_sense_input = 1'b0;
		for (w = 0; w < 5 * TICK_CYC && status[ST_BAT_INT] !== 1'b1; w++)
			@(negedge clk);
		check("inverted flag", {7'h0, status[ST_BAT_INT]}, 8'h01);
		check("inverted level", {7'h0, status[ST_BAT]}, 8'h01);
		// Second reset mid-run restores the map
		do_reset();
		check("slot_ctrl reset", slot_ctrl, RST_ZERO);
		check("dev_ctrl reset", dev_ctrl, RST_ZERO);
		check("gp_ctrl reset", gp_ctrl, RST_ZERO);
		check("clk_ctrl reset", clk_ctrl, RST_ZERO);
		i_smx_bb_master.read_block(A_DRV_VER, 1);
		check("version again", i_smx_bb_master.rd_buf[0], DRV);
		print_verdict();
	end
endmodule : smx_reg_bank_tb
